// ===== logic/pmt_consts.svh
// Purpose: Shared constants of the bus port: commands, timing, idle values.
// Assumes: Included by its bare name from the design files.
// Notes:   Idle values match the field layout of the package structs.
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// Bus command codes
`define PMT_CMD_MEM_RD  4'h6
`define PMT_CMD_MEM_WR  4'h7
`define PMT_CMD_CFG_RD  4'hA
`define PMT_CMD_CFG_WR  4'hB

// Bus clocks an initiator waits in data phase for a claim
`define PMT_DEVSEL_WAIT 3'h4

// Reset and idle values; index of configuration word zero
`define PMT_BUS_IDLE    42'h000000003DF
`define PMT_OE_OFF      8'hFF
`define PMT_CFG_REG0    0

`endif

// ===== logic/pmt_pkg.sv
// Purpose: Types of the bus port: pin groups, user request, FSM states.
// Assumes: Nothing beyond the header of constants.
// Notes:   Output enables are active low, one per pin group.
`default_nettype none
package pmt_pkg;

  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe_n;
    logic        par;
    logic        frame_n;
    logic        irdy_n;
    logic        trdy_n;
    logic        devsel_n;
    logic        stop_n;
  } pmt_bus_s;

  typedef struct packed {
    logic ad_n;
    logic cbe_n;
    logic par_n;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
  } pmt_oe_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
    logic        write;
  } pmt_mreq_s;

  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_REQ  = 5'h02,
    M_ADDR = 5'h04,
    M_DATA = 5'h08,
    M_LAST = 5'h10
  } pmt_mst_e;

  typedef enum logic [4:0] {
    T_IDLE  = 5'h01,
    T_CLAIM = 5'h02,
    T_DATA  = 5'h04,
    T_STOP  = 5'h08,
    T_END   = 5'h10
  } pmt_tgt_e;

endpackage
`default_nettype wire

// ===== logic/pmt_sync.sv
// Purpose: Two-stage synchroniser for a vector of pin inputs.
// Assumes: Bits are independent levels; no word coherence is needed.
// Notes:   Stage one feeds stage two only.
`timescale 1ns/1ps
`default_nettype none
module pmt_sync
  #(
    parameter int W = 1
  )
  (
    // System
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
  );

  logic [W-1:0] meta_reg;

  if (W < 1)
  begin : g_chk
    $error("pmt_sync: W must be at least 1");
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      meta_reg <= '0;
      q_o      <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end

endmodule
`default_nettype wire

// ===== logic/pmt_mem.sv
// Purpose: Small target memory with byte-lane writes and registered read.
// Assumes: One write and one read port on the system clock.
// Notes:   Array content is not reset; only the read register is.
`timescale 1ns/1ps
`default_nettype none
module pmt_mem
  #(
    parameter int AW = 4
  )
  (
    // System
    input  wire logic          clk_sys_i,
    input  wire logic          rst_i,
    // Write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic [3:0]    wbe_i,
    // Read port
    input  wire logic [AW-1:0] raddr_i,
    output var  logic [31:0]   rdata_o
  );

  logic [31:0] mem_reg [2**AW];

  if (AW < 1 || AW > 12)
  begin : g_chk
    $error("pmt_mem: AW out of range");
  end

  // One process owns the array; lanes are a loop inside it
  always_ff @(posedge clk_sys_i)
    if (we_i)
      for (int b = 0; b < 4; b++)
        if (wbe_i[b])
          mem_reg[waddr_i][8*b +: 8] <= wdata_i[8*b +: 8];

  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      rdata_o <= 32'h0000_0000;
    else
      rdata_o <= mem_reg[raddr_i];

endmodule
`default_nettype wire

// ===== logic/pmt_port.sv
// Purpose: Initiator and target port on a 32-bit multiplexed bus.
// Assumes: Bus clock pin is oversampled; it runs far below clk_sys_i.
// Notes:   Pins pass two flops plus one more so that each phase is
//          judged on values from just before the bus clock edge.
// Function
// - initiator drives address first, then data
// - target answers only its decoded range
// - command in address phase, byte enables after
// - little endian: enable zero covers bits 7-0
// - big endian: enable three covers byte 0
// - phases start on bus clock rising edge
// - initiator needs a target claim to continue
// - target claims only after framed address
// - initiator frames and releases before last phase
// - target decodes only framed transactions
// - initiator starts only while granted
// - configuration access needs select line asserted
// - interrupt line low while condition pending
// - initiator ready when it can complete
// - word moves when both ready lines low
// - target reads initiator ready as data valid
// - parity makes ones count even
// - parity driven by owner of data
// - request line low while needing the bus
// - target ready low when able to complete
// - stop request ends the transaction
// - reset floats all outputs and clears state
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.svh"
module pmt_port
  #(
    parameter logic [31:0] BAR_BASE = 32'h1000_0000,
    parameter int          MEM_AW   = 4,
    parameter int          IW       = 8,
    // Arbitrary value, returned at configuration word zero
    parameter logic [31:0] CFG_ID   = 32'h0000_0001
  )
  (
    // System
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // Bus pins
    input  wire logic              bus_clk_i,
    input  wire pmt_pkg::pmt_bus_s bus_i,
    output var  pmt_pkg::pmt_bus_s bus_o,
    output var  pmt_pkg::pmt_oe_s  bus_oe_o,
    input  wire logic              gnt_n_i,
    input  wire logic              idsel_i,
    output var  logic              req_n_o,
    output var  logic              req_oe_n_o,
    output var  logic              inta_n_o,
    output var  logic              inta_oe_n_o,
    // Initiator user side
    input  wire logic              mst_valid_i,
    input  wire pmt_pkg::pmt_mreq_s mst_req_i,
    input  wire logic              big_endian_i,
    output var  logic              mst_done_o,
    output var  logic              mst_err_o,
    output var  logic [31:0]       mst_rdata_o,
    // Interrupt sources
    input  wire logic [IW-1:0]     int_status_i,
    input  wire logic [IW-1:0]     int_mask_i,
    input  wire logic              int_enable_i
  );

  import pmt_pkg::*;

  localparam int SW = 44;

  if (MEM_AW < 1 || MEM_AW > 12 || IW < 1)
  begin : g_chk
    $error("pmt_port: MEM_AW or IW out of range");
  end

  // Pin sampling
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_sync;
  logic [SW-1:0] pin_d_reg;
  logic          rise_d_reg;
  logic          par_cap_reg;
  logic          frame_last_reg;

  assign pin_raw = {bus_clk_i, gnt_n_i, idsel_i, bus_i.ad, bus_i.cbe_n,
                    bus_i.frame_n, bus_i.irdy_n, bus_i.trdy_n,
                    bus_i.devsel_n, bus_i.stop_n};

  pmt_sync #(.W(SW)) u_sync
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (pin_raw),
    .q_o       (pin_sync)
  );

  wire        rise       = pin_sync[43] & ~pin_d_reg[43];
  wire        s_gnt_n    = pin_d_reg[42];
  wire        s_idsel    = pin_d_reg[41];
  wire [31:0] s_ad       = pin_d_reg[40:9];
  wire [3:0]  s_cbe_n    = pin_d_reg[8:5];
  wire        s_frame_n  = pin_d_reg[4];
  wire        s_irdy_n   = pin_d_reg[3];
  wire        s_trdy_n   = pin_d_reg[2];
  wire        s_devsel_n = pin_d_reg[1];
  wire        s_stop_n   = pin_d_reg[0];
  wire        xfer       = !s_irdy_n && !s_trdy_n;

  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      pin_d_reg      <= '0;
      rise_d_reg     <= 1'b0;
      par_cap_reg    <= 1'b0;
      frame_last_reg <= 1'b1;
    end
    else
    begin
      pin_d_reg  <= pin_sync;
      rise_d_reg <= rise;
      if (rise)
      begin
        par_cap_reg    <= ^{s_ad, s_cbe_n};
        frame_last_reg <= s_frame_n;
      end
    end

  // Lane order for the user side
  function automatic logic [31:0] lanes(input logic [31:0] w,
                                        input logic        big);
    lanes = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

  // Initiator
  pmt_mst_e   m_state_reg;
  pmt_mst_e   m_state_next;
  pmt_tgt_e   t_state_reg;
  pmt_tgt_e   t_state_next;
  logic [2:0] m_wait_reg;
  logic       done_reg;
  logic       err_reg;
  logic [31:0] rdata_reg;

  wire       m_ok    = xfer && !s_devsel_n;
  wire       m_abort = s_devsel_n && m_wait_reg == `PMT_DEVSEL_WAIT;
  wire       m_end   = m_state_reg == M_DATA && m_state_next == M_LAST;
  wire       m_busy  = m_state_reg != M_IDLE && m_state_reg != M_REQ;
  wire       bus_idle = s_frame_n && s_irdy_n;
  wire [3:0] be_bus  = big_endian_i ? {mst_req_i.be[0], mst_req_i.be[1],
                       mst_req_i.be[2], mst_req_i.be[3]}
                       : mst_req_i.be;

  always_comb
  begin
    m_state_next = m_state_reg;
    case (m_state_reg)
      M_IDLE:
        if (mst_valid_i)
          m_state_next = M_REQ;
      M_REQ:
        if (!s_gnt_n && bus_idle && t_state_reg == T_IDLE)
          m_state_next = M_ADDR;
      M_ADDR:
        m_state_next = M_DATA;
      M_DATA:
        if (m_ok || !s_stop_n || m_abort)
          m_state_next = M_LAST;
      M_LAST:
        m_state_next = M_IDLE;
      default:
        m_state_next = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      m_state_reg <= M_IDLE;
      m_wait_reg  <= 3'h0;
      done_reg    <= 1'b0;
      err_reg     <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      done_reg <= rise && m_end;
      err_reg  <= rise && m_end && !m_ok;
      if (rise)
      begin
        m_state_reg <= m_state_next;
        m_wait_reg  <= (m_state_reg == M_DATA) ? m_wait_reg + 3'h1 : 3'h0;
        if (m_end && m_ok && !mst_req_i.write)
          rdata_reg <= lanes(s_ad, big_endian_i);
      end
    end

  pmt_bus_s m_drv;
  pmt_oe_s  m_oe;

  always_comb
  begin
    m_drv = `PMT_BUS_IDLE;
    m_oe  = `PMT_OE_OFF;
    case (m_state_reg)
      M_ADDR:
      begin
        m_drv.frame_n = 1'b0;
        m_drv.ad      = {mst_req_i.addr[31:2], 2'b00};
        m_drv.cbe_n   = mst_req_i.write ? `PMT_CMD_MEM_WR
                                        : `PMT_CMD_MEM_RD;
        m_oe.frame_n  = 1'b0;
        m_oe.irdy_n   = 1'b0;
        m_oe.ad_n     = 1'b0;
        m_oe.cbe_n    = 1'b0;
      end
      M_DATA:
      begin
        // Single data phase: frame already released here
        m_drv.irdy_n  = 1'b0;
        m_drv.cbe_n   = ~be_bus;
        m_drv.ad      = lanes(mst_req_i.data, big_endian_i);
        m_oe.frame_n  = 1'b0;
        m_oe.irdy_n   = 1'b0;
        m_oe.cbe_n    = 1'b0;
        m_oe.ad_n     = !mst_req_i.write;
      end
      M_LAST:
        m_oe.irdy_n   = 1'b0;
      default:
        m_oe.stop_n   = 1'b1;
    endcase
  end

  // Target
  logic [MEM_AW-1:0] t_addr_reg;
  logic [MEM_AW-1:0] t_addr_next;
  logic              t_read_reg;
  logic              t_cfg_reg;
  logic [31:0]       mem_rdata;

  wire t_addr_phase = !s_frame_n && frame_last_reg;
  wire t_mem_cmd    = s_cbe_n == `PMT_CMD_MEM_RD || s_cbe_n == `PMT_CMD_MEM_WR;
  wire t_cfg_cmd    = s_cbe_n == `PMT_CMD_CFG_RD || s_cbe_n == `PMT_CMD_CFG_WR;
  wire t_in_range   = s_ad[31:MEM_AW+2] == BAR_BASE[31:MEM_AW+2];
  wire t_hit        = t_addr_phase && !m_busy
                      && ((t_mem_cmd && t_in_range)
                          || (t_cfg_cmd && s_idsel));
  wire t_xfer       = t_state_reg == T_DATA && xfer;
  wire t_last_word  = t_addr_reg == {MEM_AW{1'b1}};
  wire t_wr         = t_xfer && !t_read_reg && !t_cfg_reg;
  wire [31:0] t_rdata = !t_cfg_reg ? mem_rdata
                      : (t_addr_reg == `PMT_CFG_REG0) ? CFG_ID
                      : 32'h0000_0000;

  always_comb
  begin
    t_state_next = t_state_reg;
    case (t_state_reg)
      T_IDLE:
        if (rise && t_hit)
          t_state_next = T_CLAIM;
      T_CLAIM:
        t_state_next = T_DATA;
      T_DATA:
        if (s_frame_n && (xfer || s_irdy_n))
          t_state_next = T_END;
        else if (t_xfer && t_last_word)
          t_state_next = T_STOP;
      T_STOP:
        if (s_frame_n)
          t_state_next = T_END;
      T_END:
        t_state_next = T_IDLE;
      default:
        t_state_next = T_IDLE;
    endcase
  end

  always_comb
  begin
    t_addr_next = t_addr_reg;
    if (rise && t_state_reg == T_IDLE && t_hit)
      t_addr_next = s_ad[MEM_AW+1:2];
    else if (rise && t_xfer)
      t_addr_next = t_addr_reg + 1'b1;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      t_state_reg <= T_IDLE;
      t_addr_reg  <= '0;
      t_read_reg  <= 1'b0;
      t_cfg_reg   <= 1'b0;
    end
    else
    begin
      t_addr_reg <= t_addr_next;
      if (rise)
        t_state_reg <= t_state_next;
      if (rise && t_state_reg == T_IDLE && t_hit)
      begin
        t_read_reg <= !s_cbe_n[0];
        t_cfg_reg  <= t_cfg_cmd;
      end
    end

  // Read port looks ahead so data is ready for the next phase
  pmt_mem #(.AW(MEM_AW)) u_mem
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .we_i      (rise && t_wr),
    .waddr_i   (t_addr_reg),
    .wdata_i   (s_ad),
    .wbe_i     (~s_cbe_n),
    .raddr_i   (t_addr_next),
    .rdata_o   (mem_rdata)
  );

  pmt_bus_s t_drv;
  pmt_oe_s  t_oe;

  always_comb
  begin
    t_drv = `PMT_BUS_IDLE;
    t_oe  = `PMT_OE_OFF;
    if (t_state_reg != T_IDLE)
    begin
      t_oe.devsel_n = 1'b0;
      t_oe.trdy_n   = 1'b0;
      t_oe.stop_n   = 1'b0;
    end
    case (t_state_reg)
      T_CLAIM:
        t_drv.devsel_n = 1'b0;
      T_DATA:
      begin
        t_drv.devsel_n = 1'b0;
        t_drv.trdy_n   = 1'b0;
        t_drv.ad       = t_rdata;
        t_oe.ad_n      = !t_read_reg;
      end
      T_STOP:
      begin
        t_drv.devsel_n = 1'b0;
        t_drv.stop_n   = 1'b0;
      end
      default:
        t_drv.par = 1'b0;
    endcase
  end

  // Output stage: bus pins, enables and request loaded one system cycle after each detected bus clock rise; interrupt every cycle
  pmt_bus_s bus_reg;
  pmt_bus_s drv_next;
  pmt_oe_s  oe_reg;
  pmt_oe_s  oe_next;
  logic     req_reg;
  logic     req_oe_reg;
  logic     inta_reg;

  wire m_own = m_oe != `PMT_OE_OFF;

  always_comb
  begin
    drv_next       = m_own ? m_drv : t_drv;
    drv_next.par   = par_cap_reg;
    oe_next        = m_oe & t_oe;
    // Parity goes out where our own AD went out one phase before
    oe_next.par_n  = oe_reg.ad_n;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      bus_reg    <= `PMT_BUS_IDLE;
      oe_reg     <= `PMT_OE_OFF;
      req_reg    <= 1'b1;
      req_oe_reg <= 1'b1;
      inta_reg   <= 1'b1;
    end
    else
    begin
      inta_reg   <= !(int_enable_i && |(int_status_i & int_mask_i));
      req_oe_reg <= 1'b0;
      if (rise_d_reg)
      begin
        bus_reg <= drv_next;
        oe_reg  <= oe_next;
        req_reg <= m_state_reg != M_REQ;
      end
    end

  assign bus_o       = bus_reg;
  assign bus_oe_o    = oe_reg;
  assign req_n_o     = req_reg;
  assign req_oe_n_o  = req_oe_reg;
  assign inta_n_o    = inta_reg;
  assign inta_oe_n_o = inta_reg;
  assign mst_done_o  = done_reg;
  assign mst_err_o   = err_reg;
  assign mst_rdata_o = rdata_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_req_asked: assert property (
    (rise_d_reg && m_state_reg == M_REQ) |=> !req_n_o)
    else $error("request line not low while waiting");
  chk_frame_grant: assert property (
    $fell(bus_o.frame_n) |-> $past(s_gnt_n, 2) == 1'b0)
    else $error("frame driven without grant");
  chk_frame_release: assert property (
    $fell(bus_o.frame_n) |-> ##[1:100] (bus_o.frame_n && !bus_o.irdy_n))
    else $error("frame not released before final phase");
  chk_xfer_both: assert property (
    (mst_done_o && !mst_err_o) |-> $past(xfer && !s_devsel_n))
    else $error("transfer finished without both ready lines");
  chk_devsel_frame: assert property (
    $fell(bus_o.devsel_n) |-> $past(!s_frame_n, 2) && !bus_oe_o.devsel_n)
    else $error("claim without framed address");
  chk_cfg_idsel: assert property (
    ($fell(bus_o.devsel_n) && t_cfg_reg) |-> $past(s_idsel, 2))
    else $error("configuration claim without select");
  chk_inta_level: assert property (
    inta_oe_n_o == !$past(int_enable_i && |(int_status_i & int_mask_i)))
    else $error("interrupt line does not follow pending state");
  chk_par_even: assert property (
    (!bus_oe_o.par_n && $past(rise_d_reg))
    |-> ^{bus_o.par, $past(s_ad, 2), $past(s_cbe_n, 2)} == 1'b0)
    else $error("parity not even");
  chk_ad_float: assert property (
    (rise_d_reg && ((t_state_reg == T_DATA && !t_read_reg)
     || (m_state_reg == M_DATA && !mst_req_i.write))) |=> bus_oe_o.ad_n)
    else $error("data lines driven in wrong direction");
  chk_be_lanes: assert property (
    (rise_d_reg && m_state_reg == M_DATA) |=> bus_o.cbe_n[3] ==
     !(big_endian_i ? mst_req_i.be[0] : mst_req_i.be[3]))
    else $error("byte enable lane mapping wrong");

  cov_mst_write: cover property (mst_done_o && !mst_err_o && mst_req_i.write);
  cov_mst_read: cover property (mst_done_o && !mst_err_o && !mst_req_i.write);
  cov_mst_abort: cover property (mst_done_o && mst_err_o);
  cov_tgt_read: cover property (rise && t_xfer && t_read_reg);

endmodule
`default_nettype wire

// ===== sim/pmt_host_model.sv
// Purpose: Bus partner model: arbiter, target and initiator in one.
// Assumes: Pins change on the bus clock falling edge, sampled on rising.
// Notes:   Single data phase per transfer; pulls are resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.svh"
module pmt_host_model
  (
    // Bus
    input  wire logic              bclk_i,
    input  wire pmt_pkg::pmt_bus_s res_i,
    input  wire logic              req_n_i,
    output var  pmt_pkg::pmt_bus_s bus_o,
    output var  pmt_pkg::pmt_oe_s  oe_o,
    // Sideband
    output var  logic              gnt_n_o,
    output var  logic              idsel_o
  );
  import pmt_pkg::*;
  logic [31:0] c_addr, c_data, c_rdata;
  logic [3:0]  c_cmd, c_be;
  logic        c_apar, c_dpar, c_rpar, c_early, c_req, c_claim;

  initial
  begin
    bus_o   = '1;
    oe_o    = '1;
    gnt_n_o = 1'b1;
    idsel_o = 1'b0;
  end

  // Arbiter and target for one transfer started by the port
  task automatic serve(input int dly, input bit claim, input bit stp,
                       input logic [31:0] rd);
    int   n;
    logic rdn;
    n = 0;
    while (req_n_i !== 1'b0 && n < 20)
    begin
      @(posedge bclk_i);
      n++;
    end
    c_req   = (req_n_i === 1'b0);
    c_early = 1'b0;
    // Grant held back two clocks to catch an early start
    repeat (2)
    begin
      @(posedge bclk_i);
      if (res_i.frame_n === 1'b0) c_early = 1'b1;
    end
    @(negedge bclk_i);
    gnt_n_o = 1'b0;
    n = 0;
    do
    begin
      @(posedge bclk_i);
      n++;
    end while (res_i.frame_n !== 1'b0 && n < 8);
    c_addr = res_i.ad;
    c_cmd  = res_i.cbe_n;
    rdn    = (c_cmd !== `PMT_CMD_MEM_RD);
    @(negedge bclk_i);
    gnt_n_o = 1'b1;
    @(posedge bclk_i);
    c_apar = res_i.par;
    if (!claim)
      repeat (8) @(posedge bclk_i);
    else
    begin
      repeat (dly + 1) @(negedge bclk_i);
      bus_o = {rd, 4'hF, 1'b0, 2'b11, stp, 1'b0, !stp};
      oe_o  = {rdn, 4'hF, 3'b000};
      n = 0;
      do
      begin
        @(posedge bclk_i);
        n++;
      end while (res_i.irdy_n !== 1'b0 && n < 8);
      c_data = res_i.ad;
      c_be   = res_i.cbe_n;
      @(negedge bclk_i);
      bus_o = {rd, 4'hF, ^{rd, c_be}, 5'h1F};
      oe_o  = {2'b11, rdn, 5'b11000};
      @(posedge bclk_i);
      c_dpar = res_i.par;
      @(negedge bclk_i);
      oe_o = '1;
    end
  endtask

  // Initiator of one single-phase transfer towards the port
  task automatic init(input logic [3:0] cmd, input logic [31:0] addr,
                      input logic [31:0] data, input logic [3:0] be,
                      input logic sel);
    int n;
    @(negedge bclk_i);
    bus_o   = {addr, cmd, 1'b0, 5'b01111};
    oe_o    = 8'b00101111;
    idsel_o = sel;
    @(negedge bclk_i);
    bus_o   = {data, ~be, ^{addr, cmd}, 5'b10111};
    oe_o    = {!cmd[0], 7'b0000111};
    idsel_o = 1'b0;
    c_claim = 1'b0;
    n = 0;
    do
    begin
      @(posedge bclk_i);
      n++;
      if (res_i.devsel_n === 1'b0) c_claim = 1'b1;
    end while (res_i.trdy_n !== 1'b0 && res_i.stop_n !== 1'b0 && n < 8);
    c_rdata = res_i.ad;
    @(negedge bclk_i);
    bus_o = {data, ~be, ^{data, ~be}, 5'h1F};
    oe_o  = {2'b11, !cmd[0], 5'b00111};
    @(posedge bclk_i);
    c_rpar = res_i.par;
    @(negedge bclk_i);
    oe_o = '1;
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: Self-checking bench of the bus port, initiator and target.
// Assumes: Bus clock of 125 ns, unrelated in phase to the system clock.
// Notes:   Undriven data lines toggle; control lines are pulled up.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.svh"
module testbench;
  import pmt_pkg::*;
  localparam logic [31:0] BAR = 32'h1000_0000;
  // Arbitrary identity word
  localparam logic [31:0] ID  = 32'h0000_00A5;
  logic        clk_sys_i = 1'b0;
  logic        bus_clk   = 1'b0;
  logic        rst_i, mst_valid_i, big_endian_i, int_enable_i, err;
  logic        gnt_n, idsel, req_n_o, req_oe_n_o, inta_n_o, inta_oe_n_o;
  logic        mst_done_o, mst_err_o;
  logic [31:0] mst_rdata_o, rdat;
  logic [7:0]  int_status_i, int_mask_i;
  pmt_mreq_s   mst_req_i;
  pmt_bus_s    d_bus, m_bus, res;
  pmt_bus_s    last = '0;
  pmt_oe_s     d_oe, m_oe;
  logic [41:0] md, mm;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  function automatic logic [41:0] msk(input pmt_oe_s o);
    return {{32{~o.ad_n}}, {4{~o.cbe_n}}, ~o.par_n, ~o.frame_n, ~o.irdy_n,
            ~o.trdy_n, ~o.devsel_n, ~o.stop_n};
  endfunction
  assign md  = msk(d_oe);
  assign mm  = msk(m_oe);
  assign res = pmt_bus_s'((d_bus & md) | (m_bus & mm)
                          | (~(md | mm) & {~last[41:5], 5'h1F}));
  always @(posedge clk_sys_i)
    last <= res;
  always #2 clk_sys_i = ~clk_sys_i;
  always #62.5 bus_clk = ~bus_clk;

  pmt_port #(.CFG_ID(ID)) i_dut
    (
      .clk_sys_i    (clk_sys_i),
      .rst_i        (rst_i),
      .bus_clk_i    (bus_clk),
      .bus_i        (res),
      .bus_o        (d_bus),
      .bus_oe_o     (d_oe),
      .gnt_n_i      (gnt_n),
      .idsel_i      (idsel),
      .req_n_o      (req_n_o),
      .req_oe_n_o   (req_oe_n_o),
      .inta_n_o     (inta_n_o),
      .inta_oe_n_o  (inta_oe_n_o),
      .mst_valid_i  (mst_valid_i),
      .mst_req_i    (mst_req_i),
      .big_endian_i (big_endian_i),
      .mst_done_o   (mst_done_o),
      .mst_err_o    (mst_err_o),
      .mst_rdata_o  (mst_rdata_o),
      .int_status_i (int_status_i),
      .int_mask_i   (int_mask_i),
      .int_enable_i (int_enable_i)
    );

  pmt_host_model i_host
    (
      .bclk_i  (bus_clk),
      .res_i   (res),
      .req_n_i (req_oe_n_o | req_n_o),
      .bus_o   (m_bus),
      .oe_o    (m_oe),
      .gnt_n_o (gnt_n),
      .idsel_o (idsel)
    );

  task automatic chk_val(input logic [41:0] got, input logic [41:0] exp,
                         input string what);
    cmp_count++;
    if (got !== exp)
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    if (got !== exp) error_cnt++;
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // One initiator transfer of the port, partner answering as told
  task automatic mx(input logic wr, input logic [31:0] a, d,
                    input logic [3:0] be, input logic bige, input int dly,
                    input bit claim, stp, input logic [31:0] rd);
    int n;
    @(posedge clk_sys_i);
    mst_req_i    <= {a, d, be, wr};
    big_endian_i <= bige;
    mst_valid_i  <= 1'b1;
    fork
      i_host.serve(dly, claim, stp, rd);
      begin
        n = 0;
        do
        begin
          @(negedge clk_sys_i);
          n++;
        end while (mst_done_o !== 1'b1 && n < 8000);
        chk_val(mst_done_o, 1'b1, "done pulse");
        err  = mst_err_o;
        rdat = mst_rdata_o;
        @(posedge clk_sys_i);
        mst_valid_i <= 1'b0;
      end
    join
  endtask

  task automatic t_reset();
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk_val(d_oe, `PMT_OE_OFF, "oe in reset");
    chk_val(d_bus, `PMT_BUS_IDLE, "bus in reset");
    chk_val(req_oe_n_o, 1'b1, "req oe in reset");
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic t_irq();
    logic [7:0] mk [3] = '{8'h04, 8'h18, 8'h04};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys_i);
      int_status_i <= 8'h24;
      int_mask_i   <= mk[i];
      int_enable_i <= (i < 2);
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk_val({inta_n_o, inta_oe_n_o}, {2{i != 0}}, "irq");
    end
  endtask

  task automatic t_mst_le();
    mx(1'b1, 32'h0000_4000, 32'hA1B2C3D4, 4'b0101, 1'b0, 0, 1, 0, '0);
    chk_val(i_host.c_req, 1'b1, "request");
    chk_val(i_host.c_early, 1'b0, "start before grant");
    chk_val(i_host.c_addr, 32'h0000_4000, "address");
    chk_val(i_host.c_cmd, `PMT_CMD_MEM_WR, "command");
    chk_val(i_host.c_data, 32'hA1B2C3D4, "write data");
    chk_val(i_host.c_be, 4'b1010, "le lanes");
    chk_val(i_host.c_apar, ^{32'h4000, 4'h7}, "addr par");
    chk_val(i_host.c_dpar, ^{32'hA1B2C3D4, 4'hA}, "dpar");
    chk_val(err, 1'b0, "write err");
  endtask

  task automatic t_mst_be();
    mx(1'b1, 32'h0000_4010, 32'hA1B2C3D4, 4'b0011, 1'b1, 1, 1, 0, '0);
    chk_val(i_host.c_data, 32'hD4C3B2A1, "be data");
    chk_val(i_host.c_be, 4'b0011, "be lanes");
    mx(1'b0, 32'h0000_4020, '0, 4'hF, 1'b1, 2, 1, 0, 32'h11223344);
    chk_val(i_host.c_cmd, `PMT_CMD_MEM_RD, "read cmd");
    chk_val(rdat, 32'h44332211, "be read data");
    chk_val(err, 1'b0, "read err");
  endtask

  task automatic t_mst_fail();
    mx(1'b1, 32'h0000_4030, 32'h1, 4'hF, 1'b0, 0, 1, 1, '0);
    chk_val(err, 1'b1, "stop err");
    mx(1'b0, 32'h0000_4040, '0, 4'hF, 1'b0, 0, 0, 0, '0);
    chk_val(err, 1'b1, "abort err");
  endtask

  task automatic t_tgt();
    i_host.init(`PMT_CMD_MEM_WR, BAR + 32'h8, 32'h55AA_1234, 4'hF, 1'b0);
    chk_val(i_host.c_claim, 1'b1, "claim");
    i_host.init(`PMT_CMD_MEM_WR, BAR + 32'h8, 32'hFFFF_FFFF, 4'h2, 1'b0);
    i_host.init(`PMT_CMD_MEM_RD, BAR + 32'h8, '0, 4'hF, 1'b0);
    chk_val(i_host.c_rdata, 32'h55AA_FF34, "readback");
    chk_val(i_host.c_rpar, ^{32'h55AA_FF34}, "read par");
    i_host.init(`PMT_CMD_MEM_RD, 32'h2000_0008, '0, 4'hF, 1'b0);
    chk_val(i_host.c_claim, 1'b0, "out of range");
    i_host.init(`PMT_CMD_CFG_RD, '0, '0, 4'hF, 1'b0);
    chk_val(i_host.c_claim, 1'b0, "cfg unselected");
    i_host.init(`PMT_CMD_CFG_RD, '0, '0, 4'hF, 1'b1);
    chk_val(i_host.c_rdata, ID, "cfg word");
  endtask

  initial
  begin
    rst_i        = 1'b1;
    mst_valid_i  = 1'b0;
    mst_req_i    = '0;
    big_endian_i = 1'b0;
    int_enable_i = 1'b0;
    int_status_i = 8'h00;
    int_mask_i   = 8'h00;
    t_reset();
    t_irq();
    t_mst_le();
    t_mst_be();
    t_mst_fail();
    t_tgt();
    end_sim();
  end
endmodule
`default_nettype wire
